// [rtl/sepwp_core.sv]
// serial eeprom core: 64x16 array, serial command decoder, self-timed programming, protect register
`timescale 1ns/1ps
`default_nettype none
`include "sepwp_defs.svh"
module sepwp_core #(
  parameter int unsigned PROG_CYCLES = `SEPWP_PROG_TIME_NS / `SEPWP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // serial link from the host
  input  wire logic select_i,
  input  wire logic sclk_i,
  input  wire logic din_i,
  // serial data out and its drive enable
  output var  logic dout_o,
  output var  logic dout_en_o,
  // programming in progress
  output var  logic busy_o
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    sepwp_pkg::sepwp_state_t                     st;
    sepwp_pkg::sepwp_cmd_t                       cmd;
    logic                                        sel_d;
    logic                                        sclk_d;
    logic [`SEPWP_WIDTH-1:0]                     sr;
    logic [6:0]                                  cnt;
    logic [5:0]                                  addr;
    logic [5:0]                                  ptr;
    logic [`SEPWP_PAGE_WORDS-1:0][`SEPWP_WIDTH-1:0] pbuf;
    logic                                        wen;
    logic                                        prot_en;
    logic [5:0]                                  prot_addr;
    logic                                        lock;
    logic [TW-1:0]                               timer;
    logic [`SEPWP_DEPTH-1:0][`SEPWP_WIDTH-1:0]   mem;
    logic                                        dout;
    logic                                        doe;
    logic                                        busy;
  } sepwp_reg_t;

  localparam sepwp_reg_t RST_VAL = '{
    st:      sepwp_pkg::S_IDLE,
    cmd:     sepwp_pkg::C_READ,
    mem:     {`SEPWP_DEPTH{`SEPWP_ERASED_WORD}},
    default: '0
  };

  function automatic sepwp_pkg::sepwp_cmd_t cmd_decode(input logic [7:0] b);
    case (b[7:6])
      `SEPWP_OP_READ:  return sepwp_pkg::C_READ;
      `SEPWP_OP_WRITE: return sepwp_pkg::C_WRITE;
      `SEPWP_OP_PAGE:  return sepwp_pkg::C_PAGE;
      default: begin
        case (b[5:4])
          `SEPWP_EXT_EN:   return sepwp_pkg::C_EN;
          `SEPWP_EXT_DIS:  return sepwp_pkg::C_DIS;
          `SEPWP_EXT_FILL: return sepwp_pkg::C_FILL;
          default:         return sepwp_pkg::C_PROT;
        endcase
      end
    endcase
  endfunction

  // protected region runs from the boundary address up to the top word
  function automatic logic prot_hit(input logic [5:0] a, input logic en, input logic [5:0] lo);
    return en && (a >= lo);
  endfunction

  sepwp_reg_t r;
  sepwp_reg_t n;

  logic [2:0] pins_s;
  sepwp_sync #(
    .W (3)
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .d_i     ({select_i, sclk_i, din_i}),
    .q_o     (pins_s)
  );

  logic sel_s;
  logic sclk_s;
  logic din_s;
  logic rise;
  logic sel_fall;
  assign sel_s    = pins_s[2];
  assign sclk_s   = pins_s[1];
  assign din_s    = pins_s[0];
  assign rise     = sclk_s & ~r.sclk_d;
  assign sel_fall = r.sel_d & ~sel_s;

  always_comb begin
    logic [5:0] a;
    logic [2:0] nw;
    logic       ok;
    a        = '0;
    nw       = r.cnt[6:4];
    ok       = 1'b0;
    n        = r;
    n.sel_d  = sel_s;
    n.sclk_d = sclk_s;
    case (r.st)
      sepwp_pkg::S_IDLE: begin
        if (sel_s && rise && din_s) begin
          n.st  = sepwp_pkg::S_CMD;
          n.cnt = '0;
        end
      end
      sepwp_pkg::S_CMD: begin
        if (!sel_s) begin
          n.st = sepwp_pkg::S_IDLE;
        end else if (rise) begin
          n.sr  = {r.sr[14:0], din_s};
          n.cnt = r.cnt + 7'h01;
          if (r.cnt == 7'h07) begin
            n.addr = {r.sr[4:0], din_s};
            n.cmd  = cmd_decode({r.sr[6:0], din_s});
            n.cnt  = '0;
            case (n.cmd)
              sepwp_pkg::C_READ: begin
                n.ptr = n.addr;
                n.sr  = r.mem[n.addr];
                n.st  = sepwp_pkg::S_READ;
              end
              sepwp_pkg::C_EN: begin
                n.wen = 1'b1;
                n.st  = sepwp_pkg::S_WAIT;
              end
              sepwp_pkg::C_DIS: begin
                n.wen = 1'b0;
                n.st  = sepwp_pkg::S_WAIT;
              end
              default: n.st = sepwp_pkg::S_DATA;
            endcase
          end
        end
      end
      sepwp_pkg::S_READ: begin
        if (!sel_s) begin
          n.st = sepwp_pkg::S_IDLE;
        end else if (rise) begin
          n.cnt = r.cnt + 7'h01;
          if (r.cnt[3:0] == 4'hF) begin
            // no gap bit between words, so the stream is seamless
            n.ptr = r.ptr + 6'h01;
            n.sr  = r.mem[n.ptr];
            n.cnt = '0;
          end else begin
            n.sr = {r.sr[14:0], 1'b0};
          end
        end
      end
      sepwp_pkg::S_DATA: begin
        if (sel_fall) begin
          ok = (r.cnt[3:0] == 4'h0) && (nw != 3'h0) && r.wen &&
               ((r.cmd == sepwp_pkg::C_PAGE) ? (nw <= 3'h4) : (nw == 3'h1)) &&
               !((r.cmd == sepwp_pkg::C_PROT) && r.lock);
          n.st    = ok ? sepwp_pkg::S_PROG : sepwp_pkg::S_IDLE;
          n.timer = TW'(PROG_CYCLES);
        end else if (sel_s && rise) begin
          n.sr = {r.sr[14:0], din_s};
          if (r.cnt != 7'h7F) begin
            n.cnt = r.cnt + 7'h01;
          end
          if ((r.cnt[3:0] == 4'hF) && (r.cnt < 7'h40)) begin
            n.pbuf[r.cnt[5:4]] = {r.sr[14:0], din_s};
          end
        end
      end
      sepwp_pkg::S_PROG: begin
        // runs on mclk alone, so a stopped serial clock cannot stall it
        n.timer = r.timer - TW'(1);
        if (r.timer == TW'(1)) begin
          n.st = sepwp_pkg::S_READY;
          case (r.cmd)
            sepwp_pkg::C_WRITE, sepwp_pkg::C_PAGE: begin
              for (int i = 0; i < `SEPWP_PAGE_WORDS; i++) begin
                a = r.addr + 6'(i);
                if ((3'(i) < nw) && !prot_hit(a, r.prot_en, r.prot_addr)) begin
                  n.mem[a] = r.pbuf[i]; // whole word replaced, erase implied
                end
              end
            end
            sepwp_pkg::C_FILL: begin
              for (int i = 0; i < `SEPWP_DEPTH; i++) begin
                if (!prot_hit(6'(i), r.prot_en, r.prot_addr)) begin
                  n.mem[i] = r.pbuf[0];
                end
              end
            end
            default: begin
              if (!r.lock) begin
                n.prot_addr = r.pbuf[0][5:0];
                n.prot_en   = r.pbuf[0][`SEPWP_PROT_EN_BIT];
                n.lock      = r.pbuf[0][`SEPWP_PROT_LOCK_BIT];
              end
            end
          endcase
        end
      end
      sepwp_pkg::S_READY: begin
        if (!sel_s) begin
          n.st = sepwp_pkg::S_IDLE;
        end else if (rise && din_s) begin
          n.st  = sepwp_pkg::S_CMD;
          n.cnt = '0;
        end
      end
      sepwp_pkg::S_WAIT: begin
        if (!sel_s) begin
          n.st = sepwp_pkg::S_IDLE;
        end
      end
      default: n.st = sepwp_pkg::S_IDLE;
    endcase
    n.doe  = sel_s && ((n.st == sepwp_pkg::S_READ) || (n.st == sepwp_pkg::S_PROG) ||
                       (n.st == sepwp_pkg::S_READY));
    n.dout = (n.st == sepwp_pkg::S_READ) ? n.sr[15] : (n.st == sepwp_pkg::S_READY);
    n.busy = (n.st == sepwp_pkg::S_PROG);
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign dout_o    = r.dout;
  assign dout_en_o = r.doe;
  assign busy_o    = r.busy;

  // helper: cycles spent in the current programming cycle
  logic [TW:0] prog_len_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prog_len_r <= '0;
    end else begin
      prog_len_r <= (r.st == sepwp_pkg::S_PROG) ? prog_len_r + (TW+1)'(1) : '0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_prog_end;
    (r.st == sepwp_pkg::S_PROG) ##1 (r.st != sepwp_pkg::S_PROG);
  endsequence
  sequence s_last_bit_wrap;
    (r.st == sepwp_pkg::S_READ) && sel_s && rise && (r.cnt[3:0] == 4'hF) && (r.ptr == `SEPWP_LAST_ADDR);
  endsequence

  a_prog_busy_low:  assert property ((r.st == sepwp_pkg::S_PROG) && dout_en_o |-> !dout_o)
    else $error("busy not shown as low during programming");
  a_ready_high:     assert property ((r.st == sepwp_pkg::S_READY) && dout_en_o |-> dout_o)
    else $error("ready not shown as high after programming");
  a_prog_length:    assert property (s_prog_end |-> ($past(prog_len_r) == (TW+1)'(PROG_CYCLES - 1)))
    else $error("programming cycle length wrong");
  a_prog_needs_wen: assert property ($rose(r.st == sepwp_pkg::S_PROG) |-> $past(r.wen))
    else $error("programming started while write disabled");
  a_lock_freeze:    assert property (r.lock |=> r.lock && $stable(r.prot_addr) && $stable(r.prot_en))
    else $error("protect register changed after lock");
  a_ptr_wrap:       assert property (s_last_bit_wrap |=> (r.ptr == 6'h00) ##0 (r.sr == r.mem[0]))
    else $error("pointer did not wrap to zero");
  a_top_protected:  assert property (r.prot_en |=> $stable(r.mem[`SEPWP_DEPTH-1]))
    else $error("protected word altered");
  a_read_first_msb: assert property ($rose(r.st == sepwp_pkg::S_READ) |-> dout_o == r.mem[r.ptr][15])
    else $error("first read bit is not the msb of the addressed word");
  a_mem_only_prog:  assert property ((r.mem != $past(r.mem)) |-> $past(r.st) == sepwp_pkg::S_PROG)
    else $error("array changed outside a programming cycle");
  a_read_shift:     assert property ((r.st == sepwp_pkg::S_READ) && sel_s && rise && (r.cnt[3:0] != 4'hF)
                                     |=> ##1 dout_o == $past(r.sr[14], 2))
    else $error("read bit order not msb first");
endmodule // sepwp_core
`default_nettype wire

// [rtl/sepwp_defs.svh]
// constants of the serial eeprom core: sizes, encodings, reset values and timing
`ifndef SEPWP_DEFS_SVH
`define SEPWP_DEFS_SVH
`define SEPWP_DEPTH          64
`define SEPWP_WIDTH          16
`define SEPWP_PAGE_WORDS     4
`define SEPWP_ERASED_WORD    16'hFFFF
`define SEPWP_LAST_ADDR      6'h3F
`define SEPWP_OP_READ        2'h2
`define SEPWP_OP_WRITE       2'h1
`define SEPWP_OP_PAGE        2'h3
`define SEPWP_EXT_EN         2'h3
`define SEPWP_EXT_DIS        2'h0
`define SEPWP_EXT_FILL       2'h1
`define SEPWP_EXT_PROT       2'h2
`define SEPWP_PROT_LOCK_BIT  15
`define SEPWP_PROT_EN_BIT    14
`define SEPWP_CLK_PERIOD_NS  50
`define SEPWP_PROG_TIME_NS   10000000
`endif

// [rtl/sepwp_pkg.sv]
// types shared by the serial eeprom core
`default_nettype none
package sepwp_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_CMD   = 3'h1,
    S_READ  = 3'h2,
    S_DATA  = 3'h3,
    S_PROG  = 3'h4,
    S_READY = 3'h5,
    S_WAIT  = 3'h6
  } sepwp_state_t;
  typedef enum logic [2:0] {
    C_READ  = 3'h0,
    C_WRITE = 3'h1,
    C_PAGE  = 3'h2,
    C_EN    = 3'h3,
    C_DIS   = 3'h4,
    C_FILL  = 3'h5,
    C_PROT  = 3'h6
  } sepwp_cmd_t;
endpackage
`default_nettype wire

// [rtl/sepwp_sync.sv]
// two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module sepwp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sepwp_sync_t;
  sepwp_sync_t r;
  sepwp_sync_t n;
  always_comb begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign q_o = r.s2;
endmodule // sepwp_sync
`default_nettype wire

// [testbench/sepwp_host.sv]
// host model of the serial link: select, serial clock and data in
`timescale 1ns/1ps
`default_nettype none
module sepwp_host (
  // clock
  input  wire logic mclk_i,
  // link to the device
  output var  logic select_o,
  output var  logic sclk_o,
  output var  logic din_o,
  input  wire logic dout_i,
  input  wire logic dout_en_i
);
  initial begin
    select_o = 1'b0;
    sclk_o   = 1'b0;
    din_o    = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // four-clock phases keep clear of the two-flop pin synchronisers
  task automatic bit_io(input logic b, output logic q);
    din_o  <= b;
    sclk_o <= 1'b0;
    wait_n(3);
    // an undriven line reads as the inverse, so a read without drive enable fails
    @(negedge mclk_i) q = dout_en_i ? dout_i : ~dout_i;
    @(posedge mclk_i);
    sclk_o <= 1'b1;
    wait_n(4);
  endtask
  // serial clock stands low outside frames; din shows a changed level once released
  task automatic sel(input logic s);
    din_o    <= ~din_o;
    sclk_o   <= 1'b0;
    select_o <= s;
    wait_n(6);
  endtask
  task automatic send_hdr(input logic [8:0] h);
    logic q;
    for (int i = 8; i >= 0; i--) bit_io(h[i], q);
  endtask
  task automatic send_word(input logic [15:0] w);
    logic q;
    for (int i = 15; i >= 0; i--) bit_io(w[i], q);
  endtask
  // select stays high so words keep streaming
  task automatic get_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) bit_io(1'b0, w[i]);
  endtask
endmodule // sepwp_host
`default_nettype wire

// [testbench/sepwp_core_tb.sv]
// self-checking bench of the serial eeprom core
`timescale 1ns/1ps
`default_nettype none
`include "sepwp_defs.svh"
module sepwp_core_tb;
  localparam int unsigned PROG = 20;
  logic mclk_i;
  logic reset_i;
  logic select;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_en_o;
  logic busy_o;
  int   mismatches;
  int   comparisons;
  int   cycles;
  int   busy_cnt;
  sepwp_core #(
    .PROG_CYCLES (PROG)
  ) u_sepwp_core (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .select_i  (select),
    .sclk_i    (sclk),
    .din_i     (din),
    .dout_o    (dout_o),
    .dout_en_o (dout_en_o),
    .busy_o    (busy_o)
  );
  sepwp_host u_sepwp_host (
    .mclk_i    (mclk_i),
    .select_o  (select),
    .sclk_o    (sclk),
    .din_o     (din),
    .dout_i    (dout_o),
    .dout_en_i (dout_en_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  always @(negedge mclk_i) if (busy_o === 1'b1) busy_cnt++;
  task automatic read_at(input logic [5:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] w;
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr({1'b1, `SEPWP_OP_READ, a});
    u_sepwp_host.get_word(w);
    check(w, e0);
    u_sepwp_host.get_word(w);
    check(w, e1);
    u_sepwp_host.sel(1'b0);
  endtask
  // select falls to launch; sclk stays still while the cycle runs
  task automatic end_prog(input logic busy_exp);
    busy_cnt = 0;
    u_sepwp_host.sel(1'b0);
    u_sepwp_host.sel(1'b1);
    @(negedge mclk_i);
    check(16'(busy_o), 16'(busy_exp));
    if (busy_exp) check({dout_en_o, dout_o}, 16'h0002);
    u_sepwp_host.wait_n(30);
    @(negedge mclk_i);
    if (busy_exp) check(16'(dout_o), 16'h0001);
    check(16'(busy_cnt), busy_exp ? 16'(PROG) : 16'h0000);
    u_sepwp_host.sel(1'b0);
  endtask
  task automatic cmd(input logic [8:0] h, input logic [15:0] w, input logic busy_exp);
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr(h);
    u_sepwp_host.send_word(w);
    end_prog(busy_exp);
  endtask
  task automatic t_factory();
    read_at(6'h3F, `SEPWP_ERASED_WORD, `SEPWP_ERASED_WORD);
    $display("test factory done");
  endtask
  task automatic t_disabled();
    cmd({1'b1, `SEPWP_OP_WRITE, 6'h3F}, 16'h1234, 1'b0);
    read_at(6'h3F, `SEPWP_ERASED_WORD, `SEPWP_ERASED_WORD);
    $display("test disabled done");
  endtask
  task automatic t_write_wrap();
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr({1'b1, 2'h0, `SEPWP_EXT_EN, 4'h0});
    u_sepwp_host.sel(1'b0);
    cmd({1'b1, `SEPWP_OP_WRITE, 6'h3F}, 16'hA55A, 1'b1);
    cmd({1'b1, `SEPWP_OP_WRITE, 6'h00}, 16'h0F0F, 1'b1);
    cmd({1'b1, `SEPWP_OP_WRITE, 6'h3F}, 16'h1234, 1'b1);
    read_at(6'h3F, 16'h1234, 16'h0F0F);
    $display("test write and wrap done");
  endtask
  task automatic t_page();
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr({1'b1, `SEPWP_OP_PAGE, 6'h10});
    for (int i = 1; i <= `SEPWP_PAGE_WORDS; i++) u_sepwp_host.send_word(16'(i * 16'h1111));
    end_prog(1'b1);
    read_at(6'h10, 16'h1111, 16'h2222);
    read_at(6'h12, 16'h3333, 16'h4444);
    $display("test page done");
  endtask
  task automatic t_fill_protect();
    cmd({1'b1, 2'h0, `SEPWP_EXT_FILL, 4'h0}, 16'h5AA5, 1'b1);
    read_at(6'h20, 16'h5AA5, 16'h5AA5);
    cmd({1'b1, 2'h0, `SEPWP_EXT_PROT, 4'h0}, 16'hC030, 1'b1);
    cmd({1'b1, 2'h0, `SEPWP_EXT_FILL, 4'h0}, 16'h0000, 1'b1);
    read_at(6'h2F, 16'h0000, 16'h5AA5);
    cmd({1'b1, 2'h0, `SEPWP_EXT_PROT, 4'h0}, 16'h0000, 1'b0);
    cmd({1'b1, 2'h0, `SEPWP_EXT_FILL, 4'h0}, 16'h1111, 1'b1);
    read_at(6'h2F, 16'h1111, 16'h5AA5);
    $display("test fill and protect done");
  endtask
  // five page words are one too many; a disabled write must not start a cycle
  task automatic t_refused();
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr({1'b1, `SEPWP_OP_PAGE, 6'h08});
    for (int i = 0; i <= `SEPWP_PAGE_WORDS; i++) u_sepwp_host.send_word(16'h2468);
    end_prog(1'b0);
    u_sepwp_host.sel(1'b1);
    u_sepwp_host.send_hdr({1'b1, 2'h0, `SEPWP_EXT_DIS, 4'h0});
    u_sepwp_host.sel(1'b0);
    cmd({1'b1, `SEPWP_OP_WRITE, 6'h09}, 16'h7777, 1'b0);
    read_at(6'h08, 16'h1111, 16'h1111);
    $display("test refused done");
  endtask
  initial begin
    reset_i     = 1'b1;
    mismatches  = 0;
    comparisons = 0;
    cycles      = 0;
    busy_cnt    = 0;
    u_sepwp_host.wait_n(5);
    reset_i <= 1'b0;
    u_sepwp_host.wait_n(4);
    t_factory();
    t_disabled();
    t_write_wrap();
    t_page();
    t_fill_protect();
    t_refused();
    report_and_stop();
  end
endmodule // sepwp_core_tb
`default_nettype wire
